//--- rtl/mmhcc_pkg.sv
// shared constants and state types for the handshake clock-crossing adapter
package mmhcc_pkg;

    // synchronizer length used on each side unless overridden
    localparam int SYNC_STAGES_DFLT = 2;

    // default widths of the pass-through address and data paths
    localparam int ADDR_W_DFLT = 32;
    localparam int DATA_W_DFLT = 32;

    // master clock period, and the worst-case extra cycles a transfer may cost per side
    localparam int MASTER_PERIOD_NS   = 5;
    localparam int SYNC_COST_CYCLES   = 2 * SYNC_STAGES_DFLT;
    localparam int METASTABLE_CYCLES  = 1;
    localparam int WORST_EXTRA_CYCLES = SYNC_COST_CYCLES + METASTABLE_CYCLES;

    // master-side handshake states
    typedef enum logic [1:0] {
        MMHCC_M_IDLE = 2'b00,
        MMHCC_M_WAIT = 2'b01,
        MMHCC_M_DONE = 2'b10
    } mmhcc_mstate_t;

    // slave-side handshake states
    typedef enum logic [0:0] {
        MMHCC_S_IDLE = 1'b0,
        MMHCC_S_XFER = 1'b1
    } mmhcc_sstate_t;

endpackage

//--- rtl/mmhcc_sync.sv
// multi-stage flip-flop synchronizer for one control level
`timescale 1ns/1ps
`default_nettype none

module mmhcc_sync #(
    parameter int STAGES = mmhcc_pkg::SYNC_STAGES_DFLT
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    import mmhcc_pkg::*;

    logic [STAGES-1:0] chain_ff;

    // shift chain; the first stage feeds only the next stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= {chain_ff[STAGES-2:0], din};
        end
    end

    assign dout = chain_ff[STAGES-1];

endmodule
`default_nettype wire

//--- rtl/mmhcc_adapter.sv
// handshake clock-crossing adapter between one memory-mapped master and one slave
// Notes on behaviour
// R1: two state machines, each clocked only by its own domain.
// R2: only read, write and stall control cross, by request and acknowledge.
// R3: request and acknowledge toggles pass a flip-flop synchronizer; the read/write kind bits are sampled directly.
// R4: works for any clock ratio, equal asynchronous clocks included.
// R5: a master read or write is captured and stalled immediately.
// R6: only control and read data are registered; address and write data pass straight through.
// R7: stalled master holds address, data and control until released.
// R8: captured transfer raises a request synchronized into the slave domain.
// R9: slave side performs the transfer with ordinary memory-mapped signalling.
// R10: finished slave transfer returns an acknowledge synchronized into master domain.
// R11: synchronized acknowledge ends the transaction by dropping the master stall.
// R12: endpoints see only normal transfers and extra stall cycles.
// R13: at most one transfer outstanding across the adapter.
// R14: worst case adds five master and five slave cycles per transfer.
// R15: synchronizer length per domain is settable, default two stages.
// R16: default synchronizers add four cycles of each side's clock.
// R17: allow one further cycle per direction for metastable resolution.
// R18: each port lives in one domain; master never touches slave clock.
// R19: reset returns each machine idle with toggles cleared; stall while busy.
// R20: slave read data held in slave domain until the acknowledge completes.
`timescale 1ns/1ps
`default_nettype none

module mmhcc_adapter #(
    parameter int ADDR_W = mmhcc_pkg::ADDR_W_DFLT,
    parameter int DATA_W = mmhcc_pkg::DATA_W_DFLT,
    parameter int SYNC_M = mmhcc_pkg::SYNC_STAGES_DFLT,
    parameter int SYNC_S = mmhcc_pkg::SYNC_STAGES_DFLT
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] m_address,
    input  wire logic              m_read,
    input  wire logic              m_write,
    input  wire logic [DATA_W-1:0] m_writedata,
    output logic [DATA_W-1:0]      m_readdata,
    output logic                   m_waitrequest,
    input  wire logic              slave_clock,
    input  wire logic              slave_rst,
    output logic [ADDR_W-1:0]      s_address,
    output logic                   s_read,
    output logic                   s_write,
    output logic [DATA_W-1:0]      s_writedata,
    input  wire logic [DATA_W-1:0] s_readdata,
    input  wire logic              s_waitrequest
);
    import mmhcc_pkg::*;

    // master domain state
    mmhcc_mstate_t     mstate_ff;
    logic              wait_ff;
    logic              req_tgl_ff;
    logic              kind_rd_ff;
    logic              kind_wr_ff;
    logic [DATA_W-1:0] m_rdata_ff;
    logic              ack_m;

    // slave domain state
    mmhcc_sstate_t     sstate_ff;
    logic              ack_tgl_ff;
    logic              s_read_ff;
    logic              s_write_ff;
    logic [DATA_W-1:0] s_rdata_ff;
    logic              req_s;

    // handshake events seen in each domain
    logic              ack_seen;
    logic              req_pending;
    logic              s_done;

    // R3: request toggle crosses into the slave domain
    // R15: slave-side length follows its own parameter
    // R16: default two stages plus the start edge cost the slave side its cycles
    mmhcc_sync #(
        .STAGES (SYNC_S)
    ) u_req_sync (
        .clock (slave_clock),
        .rst   (slave_rst),
        .din   (req_tgl_ff),
        .dout  (req_s)
    );

    // R3: acknowledge toggle crosses back into the master domain
    // R15: master-side length follows its own parameter
    // R16: default two stages plus the release edge cost the master side its cycles
    mmhcc_sync #(
        .STAGES (SYNC_M)
    ) u_ack_sync (
        .clock (clock),
        .rst   (rst),
        .din   (ack_tgl_ff),
        .dout  (ack_m)
    );

    // R4: toggle parity decides, so no clock ratio is assumed
    // R17: a late-resolving first stage only delays the compare by one edge
    assign ack_seen    = (mstate_ff == MMHCC_M_WAIT) && (ack_m == req_tgl_ff);
    assign req_pending = (sstate_ff == MMHCC_S_IDLE) && (req_s != ack_tgl_ff);
    assign s_done      = (sstate_ff == MMHCC_S_XFER) && !s_waitrequest;

    // master domain

    // R1: master machine runs only on the master clock
    // R13: a new request is taken only from idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mstate_ff <= MMHCC_M_IDLE;
        end else begin
            unique case (mstate_ff)
                MMHCC_M_IDLE: begin
                    if (m_read || m_write) begin
                        mstate_ff <= MMHCC_M_WAIT;
                    end
                end
                MMHCC_M_WAIT: begin
                    if (ack_seen) begin
                        mstate_ff <= MMHCC_M_DONE;
                    end
                end
                MMHCC_M_DONE: begin
                    mstate_ff <= MMHCC_M_IDLE;
                end
                default: begin
                    mstate_ff <= MMHCC_M_IDLE; // unused code falls back to idle
                end
            endcase
        end
    end

    // R5: stall is high ahead of any request, so a new one is stalled at once
    // R11: drops for exactly the cycle after the acknowledge arrives
    // R19: stall held whenever the machine is not finishing
    // R14: release registered one edge after the synchronized acknowledge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !ack_seen;
        end
    end

    // R2: capture read or write kind and flip the request toggle
    // R8: the toggle is the request sent to the slave domain
    // R6: only control bits are registered here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            req_tgl_ff <= 1'b0;
            kind_rd_ff <= 1'b0;
            kind_wr_ff <= 1'b0;
        end else if ((mstate_ff == MMHCC_M_IDLE) && (m_read || m_write)) begin
            req_tgl_ff <= !req_tgl_ff;
            kind_rd_ff <= m_read;
            kind_wr_ff <= m_write && !m_read;
        end
    end

    // R20: slave-held read data is stable once the acknowledge is seen
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            m_rdata_ff <= '0;
        end else if (ack_seen && kind_rd_ff) begin
            m_rdata_ff <= s_rdata_ff;
        end
    end

    assign m_waitrequest = wait_ff;
    assign m_readdata    = m_rdata_ff;

    // slave domain

    // R1: slave machine runs only on the slave clock
    // R9: start on a synchronized request, finish when the slave stops waiting
    always_ff @(posedge slave_clock or posedge slave_rst) begin
        if (slave_rst) begin
            sstate_ff <= MMHCC_S_IDLE;
        end else begin
            unique case (sstate_ff)
                MMHCC_S_IDLE: begin
                    if (req_pending) begin
                        sstate_ff <= MMHCC_S_XFER;
                    end
                end
                MMHCC_S_XFER: begin
                    if (!s_waitrequest) begin
                        sstate_ff <= MMHCC_S_IDLE;
                    end
                end
            endcase
        end
    end

    // R9: plain strobes held until the slave stops waiting
    // R12: the slave sees an ordinary transfer
    // R7: kind bits are quiet while the master is stalled, so sampled safely
    always_ff @(posedge slave_clock or posedge slave_rst) begin
        if (slave_rst) begin
            s_read_ff  <= 1'b0;
            s_write_ff <= 1'b0;
        end else if (req_pending) begin
            s_read_ff  <= kind_rd_ff;
            s_write_ff <= kind_wr_ff;
        end else if (s_done) begin
            s_read_ff  <= 1'b0;
            s_write_ff <= 1'b0;
        end
    end

    // R10: acknowledge toggle follows the completed transfer
    // R20: read data captured and held until the next read
    always_ff @(posedge slave_clock or posedge slave_rst) begin
        if (slave_rst) begin
            ack_tgl_ff <= 1'b0;
            s_rdata_ff <= '0;
        end else if (s_done) begin
            ack_tgl_ff <= !ack_tgl_ff;
            if (s_read_ff) begin
                s_rdata_ff <= s_readdata;
            end
        end
    end

    // R6: address and write data pass through, held by the stalled master
    // R18: no master-domain logic looks at the slave clock
    assign s_address   = m_address;
    assign s_writedata = m_writedata;
    assign s_read      = s_read_ff;
    assign s_write     = s_write_ff;

    // checks

    // a new request from idle is already stalled
    a_wait_on_request: assert property ( // R5
        @(posedge clock) disable iff (rst)
        ((mstate_ff == MMHCC_M_IDLE) && (m_read || m_write)) |-> m_waitrequest)
        else $error("request not stalled at once");

    // stall drops only in the cycle after the acknowledge
    a_release_on_ack: assert property ( // R11
        @(posedge clock) disable iff (rst)
        ack_seen |=> (!m_waitrequest && (mstate_ff == MMHCC_M_DONE)))
        else $error("stall not released after acknowledge");

    // stall is low for a single cycle only
    a_release_single: assert property ( // R12
        @(posedge clock) disable iff (rst)
        !m_waitrequest |=> m_waitrequest)
        else $error("stall released for more than one cycle");

    // stall stays high while the master machine is busy or idle
    a_stall_busy: assert property ( // R19
        @(posedge clock) disable iff (rst)
        (mstate_ff != MMHCC_M_DONE) |-> m_waitrequest)
        else $error("stall low outside completion");

    // no second request while one is outstanding
    a_one_outstanding: assert property ( // R13
        @(posedge clock) disable iff (rst)
        (mstate_ff == MMHCC_M_WAIT) |=> $stable(req_tgl_ff))
        else $error("second request while busy");

    // a pending request starts a slave strobe on the next slave edge
    a_slave_start: assert property ( // R9
        @(posedge slave_clock) disable iff (slave_rst)
        req_pending |=> ((s_read || s_write) && !(s_read && s_write)))
        else $error("slave transfer not started");

    // strobe held while the slave waits
    a_slave_hold: assert property ( // R9
        @(posedge slave_clock) disable iff (slave_rst)
        ((s_read || s_write) && s_waitrequest) |=> $stable({s_read, s_write}))
        else $error("slave strobe dropped during wait");

    // acknowledge toggles exactly when the slave transfer ends
    a_ack_toggle: assert property ( // R10
        @(posedge slave_clock) disable iff (slave_rst)
        s_done |=> ((ack_tgl_ff != $past(ack_tgl_ff)) && !s_read && !s_write))
        else $error("acknowledge not returned");

    // held read data does not move between transfers
    a_rdata_held: assert property ( // R20
        @(posedge slave_clock) disable iff (slave_rst)
        (!s_done) |=> $stable(s_rdata_ff))
        else $error("held read data changed");

    // master read data matches slave-held data in the release cycle
    a_rdata_match: assert property ( // R20
        @(posedge clock) disable iff (rst)
        (ack_seen && kind_rd_ff) |=> (m_readdata == $past(s_rdata_ff)))
        else $error("read data not forwarded");

    // completed read and write, and a slave that waits
    c_read_done: cover property (
        @(posedge clock) disable iff (rst)
        ack_seen && kind_rd_ff);
    c_write_done: cover property (
        @(posedge clock) disable iff (rst)
        ack_seen && kind_wr_ff);
    c_slave_waits: cover property (
        @(posedge slave_clock) disable iff (slave_rst)
        ((s_read || s_write) && s_waitrequest) [*3]);

endmodule
`default_nettype wire

//--- tb/mmhcc_slave_model.sv
// behavioural memory-mapped slave with a random number of wait states
`timescale 1ns/1ps
`default_nettype none

module mmhcc_slave_model (
    input  wire logic        slave_clock,
    input  wire logic        slave_rst,
    input  wire logic [31:0] s_address,
    input  wire logic        s_read,
    input  wire logic        s_write,
    input  wire logic [31:0] s_writedata,
    input  wire logic [3:0]  max_wait,
    output logic [31:0]      s_readdata,
    output logic             s_waitrequest
);
    logic [31:0] mem [16];
    logic [3:0]  cnt;

    // known start contents, mirrored by the bench
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = {8{4'(i)}};
        end
    end

    // plain waitrequest slave, every action on its own clock
    always @(posedge slave_clock or posedge slave_rst) begin
        if (slave_rst) begin
            cnt           <= 4'h0;
            s_waitrequest <= 1'b1;
            s_readdata    <= 32'h5a5a_a5a5;
        end else if (!(s_read | s_write)) begin
            cnt           <= 4'($urandom_range(max_wait, 0));
            s_waitrequest <= 1'b1;
            s_readdata    <= ~s_readdata; // no stale data outside a transfer
        end else if (cnt != 4'h0) begin
            cnt        <= cnt - 4'h1;
            s_readdata <= ~s_readdata;
        end else if (s_waitrequest) begin
            s_waitrequest <= 1'b0;
            if (s_read) begin
                s_readdata <= mem[s_address[3:0]];
            end else begin
                mem[s_address[3:0]] <= s_writedata;
            end
        end else begin
            s_waitrequest <= 1'b1;
            s_readdata    <= ~s_readdata; // data only valid for one cycle
        end
    end
endmodule
`default_nettype wire

//--- tb/mmhcc_adapter_bench.sv
// self-checking bench for the handshake clock-crossing adapter
`timescale 1ns/1ps
`default_nettype none

module mmhcc_adapter_bench;
    import mmhcc_pkg::*;
    logic                   clock, rst, slave_clock, slave_rst;
    logic [ADDR_W_DFLT-1:0] m_address, s_address;
    logic [DATA_W_DFLT-1:0] m_writedata, m_readdata, s_writedata, s_readdata;
    logic                   m_read, m_write, m_waitrequest, s_read, s_write, s_waitrequest;
    logic [3:0]             slv_wait;
    logic [31:0]            mirror [16];
    logic [31:0]            exp_rd [$];
    logic [64:0]            exp_sl [$];
    int                     miscompares, compares;
    real                    shalf = 3.5;

    // master clock at 200 MHz, slave clock offset in phase, its rate set per group and equal to the master's in one group
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        slave_clock = 1'b0;
        #1.3;
        forever #shalf slave_clock = ~slave_clock;
    end

    mmhcc_adapter DUT (.clock(clock), .rst(rst), .m_address(m_address), .m_read(m_read),
        .m_write(m_write), .m_writedata(m_writedata), .m_readdata(m_readdata),
        .m_waitrequest(m_waitrequest), .slave_clock(slave_clock), .slave_rst(slave_rst),
        .s_address(s_address), .s_read(s_read), .s_write(s_write),
        .s_writedata(s_writedata), .s_readdata(s_readdata), .s_waitrequest(s_waitrequest));

    mmhcc_slave_model slave (.slave_clock(slave_clock), .slave_rst(slave_rst),
        .s_address(s_address), .s_read(s_read), .s_write(s_write),
        .s_writedata(s_writedata), .max_wait(slv_wait), .s_readdata(s_readdata),
        .s_waitrequest(s_waitrequest));

    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [64:0] got, input logic [64:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string what);
        chk_word({64'h0, got}, {64'h0, exp}, what);
    endtask

    // one master transfer, called just after a rising edge, ends at the accepting edge
    task automatic xfer(input logic rd, input logic wr, input logic [31:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        m_read      <= rd;
        m_write     <= wr;
        m_address   <= a;
        m_writedata <= d;
        if (rd) begin
            exp_rd.push_back(mirror[a[3:0]]);
        end else begin
            mirror[a[3:0]] = d;
        end
        exp_sl.push_back({~rd, a, rd ? 32'h0 : d});
        @(negedge clock);
        chk_flag(m_waitrequest, 1'b1, "stall at request");
        while (m_waitrequest !== 1'b0 && n < 400) begin
            @(negedge clock);
            n++;
        end
        if (n >= 400) begin
            miscompares++;
            test_done();
        end
        if (slv_wait == 4'h0) begin
            chk_flag(1'((n + 1) * MASTER_PERIOD_NS <= (WORST_EXTRA_CYCLES + 3)
                * (MASTER_PERIOD_NS + 2.0 * shalf)), 1'b1, "latency");
        end
        @(posedge clock);
    endtask

    // master-side watcher: read data in the release cycle, pass-through address
    always @(negedge clock) begin
        if (!rst) begin
            chk_word({33'h0, s_address}, {33'h0, m_address}, "address path");
        end
        if (!rst && m_waitrequest === 1'b0 && m_read === 1'b1) begin
            chk_word({33'h0, m_readdata},
                {33'h0, exp_rd.size() > 0 ? exp_rd.pop_front() : 32'hx}, "read data");
        end
    end

    // slave-side watcher: each completed strobe matches the oldest master request
    always @(posedge slave_clock) begin
        if (!slave_rst && (s_read | s_write) === 1'b1 && s_waitrequest === 1'b0) begin
            chk_word({s_write, s_address, s_write ? s_writedata : 32'h0},
                exp_sl.size() > 0 ? exp_sl.pop_front() : 65'hx, "slave access");
        end
    end

    // main sequence: three clock ratios, fast and slow slave, reset between groups
    initial begin
        int   k;
        logic [31:0] a;
        k = $urandom(32'h81b22465);
        for (int i = 0; i < 16; i++) begin
            mirror[i] = {8{4'(i)}};
        end
        rst         = 1'b1;
        slave_rst   = 1'b1;
        m_read      = 1'b0;
        m_write     = 1'b0;
        m_address   = 32'h0;
        m_writedata = 32'h0;
        slv_wait    = 4'h0;
        repeat (3) @(posedge clock);
        rst       <= 1'b0;
        slave_rst <= 1'b0;
        @(posedge clock);
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 24; i++) begin
                slv_wait <= (i < 12) ? 4'h0 : 4'($urandom_range(3, 0));
                k = $urandom_range(3, 0);
                a = $urandom;
                xfer(k == 0 || k == 3, k != 0, a, $urandom);
            end
            m_read    <= 1'b0;
            m_write   <= 1'b0;
            rst       <= 1'b1;
            slave_rst <= 1'b1;
            shalf = (p == 0) ? 2.5 : 11.0;
            repeat (10) @(posedge clock);
            chk_flag(m_waitrequest, 1'b1, "stall in reset");
            chk_flag(s_read | s_write, 1'b0, "strobes in reset");
            rst       <= 1'b0;
            slave_rst <= 1'b0;
            repeat (2) @(posedge clock);
        end
        test_done();
    end
endmodule
`default_nettype wire
